// File: logic/pbs_top.sv
// Pixel balance and shift stage: white balance gain, then digital shift.
// Assumes pixels arrive synchronous to clk_sys, one per valid cycle,
// and software reaches the settings over Avalon-MM with waitrequest.
//
// Contract
// RULE1: Ratio one leaves channel intensity unchanged
// RULE2: Intensity scales in proportion to ratio
// RULE3: Ratios 0.00 to 3.98 accepted per colour
// RULE4: Ratio write goes to selected colour only
// RULE5: No shift, 12-bit: all bits pass
// RULE6: Shift one, 12-bit: bits 10..0, zero
// RULE7: Shift two, 12-bit: bits 9..0, zeros
// RULE8: Shift three, 12-bit: bits 8..0, zeros
// RULE9: Shift four, 12-bit: bits 7..0, zeros
// RULE10: Bit shifted out set forces all ones
// RULE11: Host shifts only when readings stay small
// RULE12: No shift, 8-bit: ADC bits 11..4
// RULE13: Shift code zero off, one..four shifts
// RULE14: 8-bit window drops one per shift
// RULE15: Multiply before shift, clamp to full scale
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pbs_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_valid,
  input wire pbs_pkg::pbs_pix_t in_pix,
  output logic out_valid,
  output logic [11:0] out_pix
);
  pbs_pkg::pbs_bus_t bus_state;
  logic acc_wr;
  logic wr_lane0;
  logic [31:0] rd_mux;
  logic [1:0] sel;
  pbs_pkg::pbs_cfg_t cfg;
  logic [1:0] stat;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;
  logic ratio_wr;
  logic [7:0] sel_ratio;
  logic [7:0] a_ratio;
  logic a_valid;
  logic [11:0] a_val;
  logic [19:0] prod;
  logic clamp;
  logic b_valid;
  logic [11:0] b_val;
  logic b_clamp;
  logic sh_sat;

  // Bus: one wait cycle, then a single-cycle ack; keeps decode registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_state <= pbs_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        pbs_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= pbs_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        pbs_pkg::BUS_ACK: begin
          bus_state <= pbs_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= pbs_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Write lands at the edge where the master sees waitrequest low
  assign acc_wr = avs_write && bus_state == pbs_pkg::BUS_ACK;
  assign wr_lane0 = acc_wr && avs_byteenable[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == pbs_pkg::REG_SEL) begin
      rd_mux = {30'h0, sel};
    end else if (avs_address == pbs_pkg::REG_RATIO) begin
      rd_mux = {24'h0, sel_ratio};
    end else if (avs_address == pbs_pkg::REG_SHIFT) begin
      rd_mux = {29'h0, cfg.shift};
    end else if (avs_address == pbs_pkg::REG_FMT) begin
      rd_mux = {31'h0, cfg.fmt8};
    end else if (avs_address == pbs_pkg::REG_STAT) begin
      rd_mux = {30'h0, stat};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_state == pbs_pkg::BUS_IDLE) begin
      avs_readdata <= rd_mux;
    end
  end

  // Colour selector; the mono code is not a balance target
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel <= pbs_pkg::SEL_RST;
    end else if (wr_lane0 && avs_address == pbs_pkg::REG_SEL
                 && avs_writedata[1:0] != pbs_pkg::COL_MONO) begin
      sel <= avs_writedata[1:0]; // RULE4
    end
  end

  // Full byte is legal: 0x00 to 0xff spans 0.00 to 3.98
  assign ratio_wr = wr_lane0 && avs_address == pbs_pkg::REG_RATIO; // RULE3

  // Codes above four are refused so the shifter never sees them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg.shift <= pbs_pkg::SHIFT_RST;
    end else if (wr_lane0 && avs_address == pbs_pkg::REG_SHIFT
                 && avs_writedata[2:0] <= pbs_pkg::SHIFT_MAX) begin
      cfg.shift <= avs_writedata[2:0]; // RULE13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg.fmt8 <= pbs_pkg::FMT8_RST;
    end else if (wr_lane0 && avs_address == pbs_pkg::REG_FMT) begin
      cfg.fmt8 <= avs_writedata[pbs_pkg::FMT8_BIT];
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_comb begin
    stat_set = 2'h0;
    stat_set[pbs_pkg::STAT_SAT_BIT] = sh_sat;
    stat_set[pbs_pkg::STAT_CLAMP_BIT] = b_valid && b_clamp;
    stat_clr = 2'h0;
    if (wr_lane0 && avs_address == pbs_pkg::REG_STAT) begin
      stat_clr = avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat <= 2'h0;
    end else begin
      stat <= (stat & ~stat_clr) | stat_set;
    end
  end

  pbs_ratio_bank i_pbs_ratio_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(ratio_wr),
    .wr_idx(sel), // RULE4
    .wr_data(avs_writedata[7:0]),
    .cfg_idx(sel),
    .cfg_data(sel_ratio),
    .pix_idx(in_pix.col),
    .pix_data(a_ratio)
  );

  // Stage A lines the pixel up with its colour's ratio
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      a_valid <= 1'b0;
      a_val <= 12'h000;
    end else begin
      a_valid <= in_valid;
      a_val <= in_pix.val;
    end
  end

  // Gain ahead of shift; floor keeps unity exact
  always_comb begin
    prod = {8'h00, a_val} * {12'h000, a_ratio}; // RULE1 RULE2
    clamp = |prod[19:18]; // RULE15
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      b_valid <= 1'b0;
      b_val <= 12'h000;
      b_clamp <= 1'b0;
    end else begin
      b_valid <= a_valid;
      b_clamp <= clamp;
      b_val <= clamp ? pbs_pkg::PIX_FULL : prod[17:6]; // RULE15
    end
  end

  pbs_shift_sat i_pbs_shift_sat (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(b_valid),
    .in_val(b_val),
    .cfg(cfg),
    .out_valid(out_valid),
    .out_pix(out_pix),
    .out_sat(sh_sat)
  );

  a_unity_ratio: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    a_valid && a_ratio == pbs_pkg::RATIO_UNITY
    |=> b_valid && b_val == $past(a_val))
    else $error("unity ratio changed the pixel");
  a_ratio_raise: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    a_valid && a_ratio > pbs_pkg::RATIO_UNITY
    |=> b_val >= $past(a_val))
    else $error("ratio above one lowered the pixel");
  a_ratio_lower: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    a_valid && a_ratio < pbs_pkg::RATIO_UNITY
    |=> b_val <= $past(a_val))
    else $error("ratio below one raised the pixel");
  a_ratio_to_sel: assert property (@(posedge clk_sys) // RULE4
    disable iff (rst)
    ratio_wr |-> ##2 sel_ratio == $past(avs_writedata[7:0], 2))
    else $error("ratio not stored for selected colour");
  a_ratio_range_full: assert property (@(posedge clk_sys) // RULE3
    disable iff (rst)
    ratio_wr && avs_writedata[7:0] == 8'hff |-> ##2 sel_ratio == 8'hff)
    else $error("top ratio value refused");
  a_product_clamp: assert property (@(posedge clk_sys) // RULE15
    disable iff (rst)
    a_valid && (({8'h00, a_val} * {12'h000, a_ratio}) >> 6) > 20'h00fff
    |=> b_clamp && b_val == pbs_pkg::PIX_FULL)
    else $error("product not clamped to full scale");
  a_shift_code_legal: assert property (@(posedge clk_sys) // RULE13
    disable iff (rst)
    wr_lane0 && avs_address == pbs_pkg::REG_SHIFT
    |=> cfg.shift == ($past(avs_writedata[2:0]) <= pbs_pkg::SHIFT_MAX
        ? $past(avs_writedata[2:0]) : $past(cfg.shift)))
    else $error("shift code handling wrong");
  a_bus_ack_once: assert property (@(posedge clk_sys) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // One wait state: the answer comes at the second edge of a request
  a_one_wait: assert property (@(posedge clk_sys)
    disable iff (rst)
    bus_state == pbs_pkg::BUS_IDLE && (avs_read || avs_write)
    |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_idle_wait_high: assert property (@(posedge clk_sys)
    disable iff (rst)
    bus_state == pbs_pkg::BUS_IDLE && !avs_read && !avs_write
    |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_write_once: assert property (@(posedge clk_sys)
    disable iff (rst)
    acc_wr |=> !acc_wr)
    else $error("one write request landed twice");
  // Read data must not move while the master may still be taking it
  a_rdata_stands: assert property (@(posedge clk_sys)
    disable iff (rst)
    !(avs_read && bus_state == pbs_pkg::BUS_IDLE)
    |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (@(posedge clk_sys)
    disable iff (rst)
    avs_read && bus_state == pbs_pkg::BUS_IDLE
    && avs_address > pbs_pkg::REG_STAT
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped address read non-zero");
  // Mono is a pixel code only; the host cannot select it
  a_sel_no_mono: assert property (@(posedge clk_sys) // RULE4
    disable iff (rst)
    wr_lane0 && avs_address == pbs_pkg::REG_SEL
    |=> sel == ($past(avs_writedata[1:0]) != pbs_pkg::COL_MONO
        ? $past(avs_writedata[1:0]) : $past(sel)))
    else $error("colour selector write handled wrong");
  a_fmt_write: assert property (@(posedge clk_sys) // RULE12
    disable iff (rst)
    wr_lane0 && avs_address == pbs_pkg::REG_FMT
    |=> cfg.fmt8 == $past(avs_writedata[pbs_pkg::FMT8_BIT]))
    else $error("format bit not stored");
  // A clear in the same cycle as a new event must not lose the event
  a_stat_set_wins: assert property (@(posedge clk_sys) // RULE10
    disable iff (rst)
    stat_set != 2'h0 |=> (stat & $past(stat_set)) == $past(stat_set))
    else $error("status event lost");
  a_stat_clear: assert property (@(posedge clk_sys)
    disable iff (rst)
    wr_lane0 && avs_address == pbs_pkg::REG_STAT
    |=> (stat & $past(avs_writedata[1:0] & ~stat_set)) == 2'h0)
    else $error("status bit not cleared");
  // Fixed three-cycle path; the transmit side has no back-pressure
  a_pix_latency: assert property (@(posedge clk_sys)
    disable iff (rst)
    in_valid |-> ##3 out_valid)
    else $error("pixel not out three cycles after it entered");
  a_no_stray_out: assert property (@(posedge clk_sys)
    disable iff (rst)
    !in_valid |-> ##3 !out_valid)
    else $error("output pulse without a pixel");
  a_ratio_zero: assert property (@(posedge clk_sys) // RULE3
    disable iff (rst)
    a_valid && a_ratio == 8'h00 |=> b_val == 12'h000)
    else $error("zero ratio did not blank the channel");

  c_unity_pixel: cover property (@(posedge clk_sys) disable iff (rst)
    a_valid && a_ratio == pbs_pkg::RATIO_UNITY);
  c_clamp_seen: cover property (@(posedge clk_sys) disable iff (rst)
    b_valid && b_clamp);
  c_ratio_write: cover property (@(posedge clk_sys) disable iff (rst)
    ratio_wr && sel == pbs_pkg::COL_BLUE);
endmodule

// File: logic/pbs_pkg.sv
// Constants and carriers for the pixel balance and shift datapath.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package pbs_pkg;
  localparam int PIX_W = 12;
  localparam int RATIO_W = 8;
  localparam int RATIO_FRAC = 6;
  localparam int NUM_COL = 3;
  localparam int DROP8 = 4;
  localparam int CLK_PERIOD_NS = 20;

  // Word addresses on the register bus
  localparam logic [2:0] REG_SEL = 3'h0;
  localparam logic [2:0] REG_RATIO = 3'h1;
  localparam logic [2:0] REG_SHIFT = 3'h2;
  localparam logic [2:0] REG_FMT = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;

  // Colour codes; code 3 is mono and bypasses balance
  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_BLUE = 2'h2;
  localparam logic [1:0] COL_MONO = 2'h3;

  // Ratio is unsigned 2.6 fixed point: 0x40 is 1.00, 0xff is 3.98
  localparam logic [7:0] RATIO_UNITY = 8'h40;
  localparam logic [2:0] SHIFT_MAX = 3'h4;
  localparam logic [2:0] SHIFT_RST = 3'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic FMT8_RST = 1'b0;
  localparam logic [11:0] PIX_FULL = 12'hfff;
  localparam int FMT8_BIT = 0;
  localparam int STAT_SAT_BIT = 0;
  localparam int STAT_CLAMP_BIT = 1;

  typedef struct packed {
    logic [1:0] col;
    logic [11:0] val;
  } pbs_pix_t;

  typedef struct packed {
    logic fmt8;
    logic [2:0] shift;
  } pbs_cfg_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } pbs_bus_t;
endpackage

// File: logic/pbs_ratio_bank.sv
// Per-colour balance ratio store with two registered read ports.
// Assumes the writer picks the entry; out-of-range index reads unity.
`timescale 1ns/1ps
module pbs_ratio_bank #(
  parameter int N = pbs_pkg::NUM_COL,
  parameter int W = pbs_pkg::RATIO_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [1:0] cfg_idx,
  output logic [W-1:0] cfg_data,
  input wire logic [1:0] pix_idx,
  output logic [W-1:0] pix_data
);
  logic [W-1:0] mem [N];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        mem[i] <= W'(pbs_pkg::RATIO_UNITY);
      end
    end else if (wr_en && 32'(wr_idx) < N) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Mono samples see unity so they pass through unbalanced
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_data <= W'(pbs_pkg::RATIO_UNITY);
      pix_data <= W'(pbs_pkg::RATIO_UNITY);
    end else begin
      cfg_data <= (32'(cfg_idx) < N) ? mem[cfg_idx]
                                      : W'(pbs_pkg::RATIO_UNITY);
      pix_data <= (32'(pix_idx) < N) ? mem[pix_idx]
                                      : W'(pbs_pkg::RATIO_UNITY);
    end
  end
endmodule

// File: logic/pbs_shift_sat.sv
// Digital left shift with saturation and 12/8-bit output selection.
// Assumes shift codes above four never arrive.
`timescale 1ns/1ps
module pbs_shift_sat (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [11:0] in_val,
  input wire pbs_pkg::pbs_cfg_t cfg,
  output logic out_valid,
  output logic [11:0] out_pix,
  output logic out_sat
);
  logic [15:0] wide;
  logic sat;
  logic [11:0] twelve;
  logic [11:0] next_pix;

  always_comb begin
    wide = {4'h0, in_val} << cfg.shift; // RULE6 RULE7 RULE8 RULE9
    sat = |wide[15:12]; // RULE10
    twelve = sat ? pbs_pkg::PIX_FULL : wide[11:0]; // RULE10
    // Eight-bit window slides down with the shift
    next_pix = cfg.fmt8 ? {4'h0, twelve[11:pbs_pkg::DROP8]} // RULE12 RULE14
                        : twelve; // RULE5
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_pix <= 12'h000;
      out_sat <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_pix <= in_valid ? next_pix : out_pix;
      out_sat <= in_valid && sat;
    end
  end

  a_no_shift_12: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    in_valid && !cfg.fmt8 && cfg.shift == 3'h0
    |=> out_valid && out_pix == $past(in_val))
    else $error("unshifted 12-bit pixel altered");
  a_shift_one_12: assert property (@(posedge clk_sys) // RULE6
    disable iff (rst)
    in_valid && !cfg.fmt8 && cfg.shift == 3'h1 && !in_val[11]
    |=> out_pix == {$past(in_val[10:0]), 1'b0})
    else $error("shift by one wrong");
  a_shift_two_12: assert property (@(posedge clk_sys) // RULE7
    disable iff (rst)
    in_valid && !cfg.fmt8 && cfg.shift == 3'h2 && in_val[11:10] == 2'h0
    |=> out_pix == {$past(in_val[9:0]), 2'h0})
    else $error("shift by two wrong");
  a_shift_three_12: assert property (@(posedge clk_sys) // RULE8
    disable iff (rst)
    in_valid && !cfg.fmt8 && cfg.shift == 3'h3 && in_val[11:9] == 3'h0
    |=> out_pix == {$past(in_val[8:0]), 3'h0})
    else $error("shift by three wrong");
  a_shift_four_12: assert property (@(posedge clk_sys) // RULE9
    disable iff (rst)
    in_valid && !cfg.fmt8 && cfg.shift == 3'h4 && in_val[11:8] == 4'h0
    |=> out_pix == {$past(in_val[7:0]), 4'h0})
    else $error("shift by four wrong");
  a_sat_all_ones: assert property (@(posedge clk_sys) // RULE10
    disable iff (rst)
    in_valid && cfg.shift != 3'h0
    && (in_val >> (4'hc - {1'b0, cfg.shift})) != 12'h000
    |=> out_sat && out_pix == ($past(cfg.fmt8) ? 12'h0ff : 12'hfff))
    else $error("overflow did not saturate");
  a_eight_bit_top: assert property (@(posedge clk_sys) // RULE12
    disable iff (rst)
    in_valid && cfg.fmt8 && cfg.shift == 3'h0
    |=> out_pix == {4'h0, $past(in_val[11:4])})
    else $error("8-bit unshifted window wrong");
  a_eight_bit_one: assert property (@(posedge clk_sys) // RULE14
    disable iff (rst)
    in_valid && cfg.fmt8 && cfg.shift == 3'h1 && !in_val[11]
    |=> out_pix == {4'h0, $past(in_val[10:3])})
    else $error("8-bit shift by one window wrong");
  a_eight_bit_four: assert property (@(posedge clk_sys) // RULE14
    disable iff (rst)
    in_valid && cfg.fmt8 && cfg.shift == 3'h4 && in_val[11:8] == 4'h0
    |=> out_pix == {4'h0, $past(in_val[7:0])})
    else $error("8-bit shift by four window wrong");

  c_saturate: cover property (@(posedge clk_sys) disable iff (rst)
    out_valid && out_sat);
  c_eight_shift: cover property (@(posedge clk_sys) disable iff (rst)
    in_valid && cfg.fmt8 && cfg.shift == 3'h3);
endmodule

// File: test/pbs_stream_model.sv
// Sensor ADC source and transmit-path sink around the pixel stage.
// Assumes the bench requests one pixel per cycle through send.
`timescale 1ns/1ps
module pbs_stream_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic send,
  input wire pbs_pkg::pbs_pix_t send_pix,
  output pbs_pkg::pbs_pix_t in_pix,
  output logic in_valid,
  input wire logic out_valid,
  input wire logic [11:0] out_pix
);
  logic [11:0] got_q[$];

  // Idle lines toggle so a stale pixel can never look valid
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_valid <= 1'b0;
      in_pix <= '0;
    end else begin
      in_valid <= send;
      in_pix <= send ? send_pix : ~in_pix;
    end
  end

  // Transmit path takes every pulse, no back-pressure
  always @(posedge clk_sys) begin
    if (!rst && out_valid === 1'b1) begin
      got_q.push_back(out_pix);
    end
  end
endmodule

// File: test/pixel_balance_and_shift_test.sv
// Self-checking bench for the pixel balance and shift stage.
// Assumes the Avalon-MM slave and stream model in pbs_stream_model.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module pixel_balance_and_shift_test;
  logic clk_sys;
  logic rst;
  logic [2:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic in_valid;
  pbs_pkg::pbs_pix_t in_pix;
  logic out_valid;
  logic [11:0] out_pix;
  logic send;
  pbs_pkg::pbs_pix_t send_pix;
  int num_errors;
  int tests_run;
  logic [31:0] rd;
  logic [11:0] pv[10];
  logic [7:0] rat[3];
  logic [2:0] sh;
  logic f8;

  pbs_top i_pbs_top (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_pix(in_pix), .out_valid(out_valid), .out_pix(out_pix));
  pbs_stream_model i_pbs_stream_model (.clk_sys(clk_sys), .rst(rst),
    .send(send), .send_pix(send_pix), .in_pix(in_pix),
    .in_valid(in_valid), .out_valid(out_valid), .out_pix(out_pix));

  initial begin
    clk_sys = 1'b0;
    forever #(pbs_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [2:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      stop_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf, rd);
    `CHK(rd, e)
  endtask

  function automatic logic [11:0] expect_pix(input logic [11:0] v,
    input logic [7:0] r, input logic [2:0] s, input logic m8);
    logic [19:0] p;
    logic [15:0] w;
    p = (v * r) >> 6;
    if (p > 20'hfff) p = 20'hfff;
    w = p[11:0] << s;
    if (w[15:12] != 4'h0) return m8 ? 12'h0ff : 12'hfff;
    return m8 ? {4'h0, w[11:4]} : w[11:0];
  endfunction

  // Back-to-back pixels, colour cycling red, green, blue, mono
  task automatic burst(input int n);
    int k;
    logic [1:0] c;
    logic [11:0] g;
    for (k = 0; k < n; k++) begin
      @(posedge clk_sys);
      send <= 1'b1;
      send_pix <= '{col: k[1:0], val: pv[k]};
    end
    @(posedge clk_sys);
    send <= 1'b0;
    k = 0;
    while (i_pbs_stream_model.got_q.size() < n && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(i_pbs_stream_model.got_q.size(), n)
    for (k = 0; k < n && i_pbs_stream_model.got_q.size() > 0; k++) begin
      c = k[1:0];
      g = i_pbs_stream_model.got_q.pop_front();
      `CHK(g, expect_pix(pv[k], c == 2'h3 ? 8'h40 : rat[c], sh, f8))
    end
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    send = 1'b0;
    send_pix = '0;
    num_errors = 0;
    tests_run = 0;
    // Values straddle the saturation edge of every shift
    pv = '{12'h0ff, 12'h100, 12'h1ff, 12'h200, 12'h3ff, 12'h400,
      12'h7ff, 12'h800, 12'hfff, 12'ha5c};
    rat = '{8'h40, 8'h40, 8'h40};
    sh = 3'h0;
    f8 = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(pbs_pkg::REG_SEL, 32'h0);
    rd_chk(pbs_pkg::REG_RATIO, 32'h40);
    rd_chk(pbs_pkg::REG_SHIFT, 32'h0);
    rd_chk(pbs_pkg::REG_FMT, 32'h0);
    rd_chk(pbs_pkg::REG_STAT, 32'h0);
    rd_chk(3'h5, 32'h0);
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 5; s++) begin
        sh = s[2:0];
        f8 = m[0];
        wr_reg(pbs_pkg::REG_SHIFT, {29'h0, sh});
        wr_reg(pbs_pkg::REG_FMT, {31'h0, f8});
        burst(10);
      end
    end
    rd_chk(pbs_pkg::REG_STAT, 32'h1);
    wr_reg(pbs_pkg::REG_STAT, 32'h3);
    rd_chk(pbs_pkg::REG_STAT, 32'h0);
    wr_reg(pbs_pkg::REG_SHIFT, 32'h5);
    rd_chk(pbs_pkg::REG_SHIFT, 32'h4);
    // Selector first, then the ratio, as the host must
    rat = '{8'h00, 8'h4d, 8'hff};
    for (int c = 0; c < 3; c++) begin
      wr_reg(pbs_pkg::REG_SEL, c);
      wr_reg(pbs_pkg::REG_RATIO, {24'h0, rat[c]});
    end
    wr_reg(pbs_pkg::REG_SEL, 32'h3);
    rd_chk(pbs_pkg::REG_SEL, 32'h2);
    bus(1'b1, pbs_pkg::REG_RATIO, 32'h11, 4'h0, rd);
    for (int c = 0; c < 3; c++) begin
      wr_reg(pbs_pkg::REG_SEL, c);
      rd_chk(pbs_pkg::REG_RATIO, {24'h0, rat[c]});
    end
    f8 = 1'b0;
    wr_reg(pbs_pkg::REG_FMT, 32'h0);
    for (int s = 0; s < 2; s++) begin
      sh = s[2:0];
      wr_reg(pbs_pkg::REG_SHIFT, {29'h0, sh});
      burst(10);
    end
    rd_chk(pbs_pkg::REG_STAT, 32'h3);
    stop_test();
  end
endmodule
